/* File: rtl/scs_top.sv */
// clock source select and internal frequency control
// assumes clk 100 MHz, pins sampled here, fuses static after programming
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scs_top (
	// system
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// configuration fuses
	input wire logic [2:0] clock_source_select,
	input wire logic pll_fuse,
	// oscillator source ticks, one per half period, and the clock input pin level
	input wire logic hfosc_tick,
	input wire logic lfosc_tick,
	input wire logic clock_input_pin,
	// pin control
	output logic clk_in_pin_is_io,
	output logic clk_out_pin_is_io,
	output logic clock_output_pin,
	output logic clock_output_pin_oe_n,
	output logic [1:0] amp_gain,
	output logic sys_clk_level,
	output logic int_clk_level,
	// axi4-lite slave
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	////////////////////////////////////////////////////////////////////////
	// reset synchroniser
	logic rst_a;
	logic rst_n;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin and tick synchronisers
	logic [2:0] sy1;
	logic [2:0] sy2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1 <= 3'h0;
			sy2 <= 3'h0;
		end else if (clk_en) begin
			sy1 <= {clock_input_pin, lfosc_tick, hfosc_tick};
			sy2 <= sy1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fuses captured after reset release, never writable
	scs_pkg::scs_mode_t mode;
	logic pll_on;
	logic fuse_done;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= scs_pkg::SCS_INTIO;
			pll_on <= 1'b0;
			fuse_done <= 1'b0;
		end else if (clk_en && !fuse_done) begin
			mode <= scs_pkg::scs_mode_t'(clock_source_select);
			pll_on <= pll_fuse;
			fuse_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode decode
	wire is_rc = (mode == scs_pkg::SCS_RCCLK) || (mode == scs_pkg::SCS_RC_IO_MODE);
	wire is_int = (mode == scs_pkg::SCS_INTCLK) || (mode == scs_pkg::SCS_INTIO);
	wire is_xtal = (mode == scs_pkg::SCS_HS) || (mode == scs_pkg::SCS_XT) ||
		(mode == scs_pkg::SCS_LP);
	wire drive_clkout = (mode == scs_pkg::SCS_RCCLK) || (mode == scs_pkg::SCS_INTCLK);
	// input pin is I/O only in internal modes
	wire in_io = is_int;
	// output pin is I/O in rc io, internal io and external clock
	wire out_io = (mode == scs_pkg::SCS_RC_IO_MODE) || (mode == scs_pkg::SCS_INTIO) ||
		(mode == scs_pkg::SCS_EC);
	wire [1:0] gain = (mode == scs_pkg::SCS_HS) ? scs_pkg::SCS_GAIN_HIGH :
		(mode == scs_pkg::SCS_XT) ? scs_pkg::SCS_GAIN_MED :
		(mode == scs_pkg::SCS_LP) ? scs_pkg::SCS_GAIN_LOW : scs_pkg::SCS_GAIN_OFF;

	////////////////////////////////////////////////////////////////////////
	// internal source: 16 MHz locked source or 500 kHz oscillator
	wire src_tick = pll_on ? sy2[0] : sy2[1];
	logic [1:0] fsel;
	scs_post_if pif ();
	assign pif.fsel = fsel;
	assign pif.src_tick = src_tick;
	scs_postscaler u_post (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pif(pif)
	);

	////////////////////////////////////////////////////////////////////////
	// selected system clock level and its rising edges
	wire sel_level = is_int ? pif.out_clk : sy2[2];
	logic sel_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= 1'b0;
		end else if (clk_en) begin
			sel_q <= sel_level;
		end
	end
	wire sys_rise = clk_en & sel_level & ~sel_q;

	////////////////////////////////////////////////////////////////////////
	// clock out: system clock divided by four
	logic [1:0] div4;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div4 <= 2'h0;
		end else if (sys_rise) begin
			div4 <= div4 + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal oscillator settling: locked then stable
	logic [9:0] settle;
	wire locked = (settle >= 10'(scs_pkg::LOCK_CYCLES));
	wire stable = (settle >= 10'(scs_pkg::STABLE_CYCLES));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle <= 10'h0;
		end else if (clk_en && !stable) begin
			settle <= settle + 10'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path
	logic aw_hold;
	logic w_hold;
	logic [3:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] strb_q;
	logic bvalid;
	wire aw_take = s_awvalid & ~aw_hold & ~bvalid;
	wire w_take = s_wvalid & ~w_hold & ~bvalid;
	wire wr_go = clk_en & aw_hold & w_hold & ~bvalid;
	wire wr_ctrl = wr_go && (aw_q == scs_pkg::OSC_CTRL_OFS);
	wire wr_ok = (aw_q == scs_pkg::OSC_CTRL_OFS) || (aw_q == scs_pkg::CFG_VIEW_OFS);
	logic [1:0] bresp;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 4'h0;
			w_q <= 32'h0;
			strb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= scs_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_hold <= 1'b1;
				aw_q <= s_awaddr;
			end
			if (w_take) begin
				w_hold <= 1'b1;
				w_q <= s_wdata;
				strb_q <= s_wstrb;
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? scs_pkg::RESP_OKAY : scs_pkg::RESP_SLVERR;
			end else if (bvalid && s_bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// frequency select register, the only writable field
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fsel <= scs_pkg::FSEL_RESET;
		end else if (wr_ctrl && strb_q[0]) begin
			fsel <= w_q[scs_pkg::FSEL_LSB +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path
	wire [31:0] ctrl_word = {26'h0, fsel, locked, stable, 2'h0};
	wire [31:0] cfg_word = {28'h0, pll_on, mode};
	wire rd_ok = (s_araddr == scs_pkg::OSC_CTRL_OFS) || (s_araddr == scs_pkg::CFG_VIEW_OFS);
	wire [31:0] rd_word = (s_araddr == scs_pkg::OSC_CTRL_OFS) ? ctrl_word :
		(s_araddr == scs_pkg::CFG_VIEW_OFS) ? cfg_word : 32'h0;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	wire ar_take = clk_en & s_arvalid & ~rvalid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= scs_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= rd_ok ? scs_pkg::RESP_OKAY : scs_pkg::RESP_SLVERR;
			end else if (rvalid && s_rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_awready = clk_en & ~aw_hold & ~bvalid;
	assign s_wready = clk_en & ~w_hold & ~bvalid;
	assign s_bvalid = bvalid;
	assign s_bresp = bresp;
	assign s_arready = clk_en & ~rvalid;
	assign s_rvalid = rvalid;
	assign s_rdata = rdata;
	assign s_rresp = rresp;
	assign clk_in_pin_is_io = in_io;
	assign clk_out_pin_is_io = out_io;
	assign clock_output_pin = drive_clkout & div4[1];
	assign clock_output_pin_oe_n = ~(drive_clkout | is_xtal);
	assign amp_gain = gain;
	assign sys_clk_level = sel_q;
	assign int_clk_level = pif.out_clk;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_reset_fsel: assert property (@(posedge clk) $rose(rst_n) |-> fsel == 2'h2)
		else $error("select not 10 after reset");
	a_fsel_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl && strb_q[0] |=> fsel == $past(w_q[5:4])) else $error("select write lost");
	a_rc_pins: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_RCCLK |-> !clk_in_pin_is_io && !clk_out_pin_is_io && !clock_output_pin_oe_n)
		else $error("rc clockout pins wrong");
	a_rc_io_mode_pins: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_RC_IO_MODE |-> clk_out_pin_is_io && clock_output_pin_oe_n)
		else $error("rc io pins wrong");
	a_intclk_pins: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_INTCLK |-> clk_in_pin_is_io && !clk_out_pin_is_io)
		else $error("internal clockout pins wrong");
	a_intio_pins: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_INTIO |-> clk_in_pin_is_io && clk_out_pin_is_io)
		else $error("internal io pins wrong");
	a_ec_pins: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_EC |-> !clk_in_pin_is_io && clk_out_pin_is_io)
		else $error("external clock pins wrong");
	a_hs_gain: assert property (@(posedge clk) disable iff (!rst_n)
		mode == scs_pkg::SCS_HS |-> amp_gain == 2'h3) else $error("gain wrong");
	a_flags_order: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_word[2] |-> ctrl_word[3]) else $error("stable before locked");
	a_fuse_fixed: assert property (@(posedge clk) disable iff (!rst_n)
		fuse_done && $past(fuse_done) |-> $stable(pll_on)) else $error("pll fuse changed");
	c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_ctrl);
	c_read: cover property (@(posedge clk) disable iff (!rst_n) ar_take && rd_ok);
	c_stable: cover property (@(posedge clk) disable iff (!rst_n) $rose(stable));
	c_int_rise: cover property (@(posedge clk) disable iff (!rst_n) pif.out_tick);
endmodule : scs_top
`default_nettype wire

/* File: rtl/scs_pkg.sv */
// package for the system clock source select block
// assumes a single 100 MHz system clock and an AXI4-Lite register slave
package scs_pkg;
	// clock source modes held in the first configuration word
	typedef enum logic [2:0] {
		SCS_LP = 3'h0, // low_power_crystal_mode
		SCS_XT = 3'h1, // medium_gain_crystal_mode
		SCS_HS = 3'h2, // high_gain_crystal_mode
		SCS_EC = 3'h3, // external_clock_mode
		SCS_INTIO = 3'h4, // internal_osc_io_mode
		SCS_INTCLK = 3'h5, // internal_osc_clockout_mode
		SCS_RC_IO_MODE = 3'h6, // rc_io_mode
		SCS_RCCLK = 3'h7 // rc_clockout_mode
	} scs_mode_t;
	// amplifier gain driven to the resonator
	typedef enum logic [1:0] {
		SCS_GAIN_OFF = 2'h0,
		SCS_GAIN_LOW = 2'h1,
		SCS_GAIN_MED = 2'h2,
		SCS_GAIN_HIGH = 2'h3
	} scs_gain_t;
	// postscaler switch states, one-hot
	typedef enum logic [1:0] {
		SCS_SW_RUN = 2'b01,
		SCS_SW_WAIT = 2'b10
	} scs_sw_t;
	// register map (byte addresses)
	localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
	localparam logic [3:0] CFG_VIEW_OFS = 4'h4;
	// oscillator control field layout
	localparam int FSEL_LSB = 4;
	localparam int LOCKED_BIT = 3;
	localparam int STABLE_BIT = 2;
	localparam logic [1:0] FSEL_RESET = 2'h2;
	// divide-by-4 for the clock out pin
	localparam int CLKOUT_DIV = 4;
	// settling times of the internal oscillator, in us
	localparam int LOCK_TIME_US = 2;
	localparam int STABLE_TIME_US = 5;
	localparam int CLK_MHZ = 100;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	localparam int STABLE_CYCLES = STABLE_TIME_US * CLK_MHZ;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scs_pkg

/* File: rtl/scs_post_if.sv */
// interface between control and the glitch-free postscaler
// assumes both ends on clk
`timescale 1ns/1ps
`default_nettype none
interface scs_post_if;
	logic [1:0] fsel;
	logic src_tick;
	logic out_clk;
	logic out_tick;
	modport ctrl (output fsel, output src_tick, input out_clk, input out_tick);
	modport post (input fsel, input src_tick, output out_clk, output out_tick);
endinterface : scs_post_if
`default_nettype wire

/* File: rtl/scs_postscaler.sv */
// postscaler: divides the internal source by 1, 2, 4 or 8
// assumes src_tick marks each source half period on clk
`timescale 1ns/1ps
`default_nettype none
module scs_postscaler (
	// system
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// link to control
	scs_post_if.post pif
);
	logic [3:0] cnt;
	logic [1:0] fsel_act;
	logic out_q;
	wire [3:0] next_cnt = cnt + 4'h1;
	// divided level per setting: 11 /1, 10 /2, 01 /4, 00 /8; one tick is a source half period
	wire lvl_new = (fsel_act == 2'h3) ? next_cnt[0] :
		(fsel_act == 2'h2) ? next_cnt[1] :
		(fsel_act == 2'h1) ? next_cnt[2] : next_cnt[3];
	// all dividers low together only when counter wraps to zero
	wire all_low = (next_cnt == 4'h0);

	////////////////////////////////////////////////////////////////////////
	// counter, output level and safe divisor switch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			out_q <= 1'b0;
			fsel_act <= scs_pkg::FSEL_RESET;
		end else if (clk_en && pif.src_tick) begin
			cnt <= next_cnt;
			out_q <= all_low ? 1'b0 : lvl_new;
			if (all_low) begin
				fsel_act <= pif.fsel;
			end
		end
	end

	assign pif.out_clk = out_q;
	assign pif.out_tick = clk_en & pif.src_tick & ~out_q & lvl_new;

	// selection changes only while output is low
	a_switch_low: assert property (@(posedge clk) disable iff (!rst_n)
		fsel_act != $past(fsel_act) |-> !out_q) else $error("divisor switched high");
endmodule : scs_postscaler
`default_nettype wire

/* File: sim/scs_osc_model.sv */
// oscillator sources at the far side of the clock select block
// assumes the bench clk; sources run free, scaled to a few clk cycles
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
	parameter int HF_GAP = 4,
	parameter int LF_GAP = 8,
	parameter int PIN_HALF = 6
) (
	// system
	input wire logic clk,
	// sources
	output logic hfosc_tick,
	output logic lfosc_tick,
	output logic clock_input_pin
);
	int hf_cnt = 0;
	int lf_cnt = 0;
	int pin_cnt = 0;
	initial begin
		hfosc_tick = 1'b0;
		lfosc_tick = 1'b0;
		clock_input_pin = 1'b0;
	end
	// one tick per source half period; the fast source stands for the locked one
	always @(posedge clk) begin
		hf_cnt <= (hf_cnt == HF_GAP - 1) ? 0 : hf_cnt + 1;
		lf_cnt <= (lf_cnt == LF_GAP - 1) ? 0 : lf_cnt + 1;
		hfosc_tick <= (hf_cnt == 0);
		lfosc_tick <= (lf_cnt == 0);
	end
	// logic-level clock or rc swing on the input pin
	always @(posedge clk) begin
		pin_cnt <= (pin_cnt == PIN_HALF - 1) ? 0 : pin_cnt + 1;
		if (pin_cnt == PIN_HALF - 1) begin
			clock_input_pin <= ~clock_input_pin;
		end
	end
endmodule : scs_osc_model
`default_nettype wire

/* File: sim/system_clock_source_select_bench.sv */
// self-checking bench for the clock source select block
// assumes scs_top with an axi4-lite slave and the oscillator model
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_bench;
	logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, pll_fuse = 1'b1;
	logic [2:0] clock_source_select = 3'h5;
	logic hfosc_tick, lfosc_tick, clock_input_pin;
	logic in_io, out_io, ck_out, ck_oe_n, sys_lv, int_lv;
	logic [1:0] amp_gain, s_bresp, s_rresp;
	logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	int r_int, r_sys, r_out, r_pin;
	logic [31:0] rd, wd;
	logic [1:0] rsp;
	logic p;
	always #5 clk = ~clk;
	scs_osc_model osc (.clk(clk), .hfosc_tick(hfosc_tick), .lfosc_tick(lfosc_tick),
		.clock_input_pin(clock_input_pin));
	scs_top dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
		.clock_source_select(clock_source_select), .pll_fuse(pll_fuse),
		.hfosc_tick(hfosc_tick), .lfosc_tick(lfosc_tick), .clock_input_pin(clock_input_pin),
		.clk_in_pin_is_io(in_io), .clk_out_pin_is_io(out_io), .clock_output_pin(ck_out),
		.clock_output_pin_oe_n(ck_oe_n), .amp_gain(amp_gain), .sys_clk_level(sys_lv),
		.int_clk_level(int_lv), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
	////////////////////////////////////////////////////////////////////////////////
	// verdict, comparison and timeout
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// expectations
	function automatic logic [31:0] near(input int a, input int b, input int tol);
		return (a - b <= tol && b - a <= tol) ? 32'h1 : 32'h0;
	endfunction : near
	function automatic logic [31:0] pins(input logic [2:0] m);
		logic gi, go, oe;
		gi = (m == 3'h4 || m == 3'h5);
		go = (m == 3'h3 || m == 3'h4 || m == 3'h6);
		oe = !(m == 3'h5 || m == 3'h7 || m <= 3'h2);
		return {27'h0, gi, go, oe, (m <= 3'h2) ? m[1:0] + 2'h1 : 2'h0};
	endfunction : pins
	// rising edges of the postscaler output in 640 cycles, per divisor code
	function automatic int int_rises(input logic pf, input logic [1:0] f);
		return (pf ? 160 : 80) / (2 * (1 << (3 - f)));
	endfunction : int_rises
	////////////////////////////////////////////////////////////////////////////////
	// bus cycles, reset and edge counting
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		// let an edge pass so the previous transfer's release has landed
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw && s_awready === 1'b1) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready === 1'b1) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
		end while (s_bvalid !== 1'b1);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		ar = 1'b1;
		// let an edge pass so the previous transfer's release has landed
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (ar && s_arready === 1'b1) begin
				ar = 1'b0;
				s_arvalid <= 1'b0;
			end
		end while (s_rvalid !== 1'b1);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask : axi_read
	task automatic reset_dut(input logic [2:0] m, input logic pf);
		clock_source_select <= m;
		pll_fuse <= pf;
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : reset_dut
	task automatic measure;
		logic pi, ps, po, pp;
		r_int = 0;
		r_sys = 0;
		r_out = 0;
		r_pin = 0;
		{pi, ps, po, pp} = {int_lv, sys_lv, ck_out, clock_input_pin};
		repeat (640) begin
			@(posedge clk);
			r_int += (int_lv === 1'b1 && pi === 1'b0);
			r_sys += (sys_lv === 1'b1 && ps === 1'b0);
			r_out += (ck_out === 1'b1 && po === 1'b0);
			r_pin += (clock_input_pin && !pp);
			{pi, ps, po, pp} = {int_lv, sys_lv, ck_out, clock_input_pin};
		end
	endtask : measure
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(29));
		// every fuse mode, pin roles, reset value and settle flags
		for (int m = 0; m < 8; m++) begin
			p = $urandom % 2;
			reset_dut(m[2:0], p);
			axi_read(4'h0, rd, rsp);
			check(rd, 32'h20);
			axi_read(4'h4, rd, rsp);
			check(rd, {28'h0, p, m[2:0]});
			axi_write(4'h4, $urandom, rsp);
			axi_read(4'h4, rd, rsp);
			check(rd, {28'h0, p, m[2:0]});
			check({27'h0, in_io, out_io, ck_oe_n, amp_gain}, pins(m[2:0]));
			measure();
			if (m == 3 || m >= 6) begin
				check(near(r_sys, r_pin, 2), 32'h1);
			end
			if (m == 4 || m == 5) begin
				check(near(r_sys, int_rises(p, 2'h2), 2), 32'h1);
			end
			check(near(r_out, (m == 5) ? int_rises(p, 2'h2) / 4 : (m == 7) ? r_pin / 4 : 0,
				(m == 5 || m == 7) ? 2 : 0), 32'h1);
			axi_read(4'h0, rd, rsp);
			check(rd, 32'h2c);
			$display("test mode %0d done", m);
		end
		// every divisor code on both fuse settings, changed back to back
		for (int q = 0; q < 2; q++) begin
			reset_dut(3'h5, q[0]);
			repeat (600) @(posedge clk);
			for (int f = 3; f >= 0; f--) begin
				wd = ($urandom & 32'hffffffcf) | (f << 4);
				axi_write(4'h0, wd, rsp);
				check(rsp, 2'h0);
				axi_read(4'h0, rd, rsp);
				check(rd, {26'h0, f[1:0], 4'hc});
				// the divisor switches at the next counter wrap, at most 16 source ticks away
				repeat (150) @(posedge clk);
				measure();
				check(near(r_int, int_rises(q[0], f[1:0]), 2), 32'h1);
				check(near(r_out, int_rises(q[0], f[1:0]) / 4, 2), 32'h1);
			end
			$display("test divisors fuse %0d done", q);
		end
		// clock enable low freezes the divided clocks and the bus
		clk_en <= 1'b0;
		@(posedge clk);
		wd = {30'h0, int_lv, sys_lv};
		repeat (50) @(posedge clk);
		check({30'h0, int_lv, sys_lv}, wd);
		check(s_arready, 1'b0);
		clk_en <= 1'b1;
		$display("test clock enable done");
		// unmapped place refused, register left alone
		axi_write(4'h8, 32'h30, rsp);
		check(rsp, 2'h2);
		axi_read(4'h8, rd, rsp);
		check(rsp, 2'h2);
		axi_read(4'h0, rd, rsp);
		check(rd, 32'h0c);
		$display("test unmapped done");
		give_verdict();
	end
endmodule : system_clock_source_select_bench
`default_nettype wire
